/* src/sspi_host.sv */
/*
  Serial sensor host: takes orders over APB and runs register
  write and read frames, single or burst, on a 3-wire or 4-wire
  serial port whose clock it divides from pclk.
  Assumes a slave device that samples on rising clock edges and
  drives its data on falling edges.
*/
// Decided for this implementation: the APB interface to the registers.
`include "sspi_map.svh"
module sspi_host
(
  input  wire logic        pclk,          // System clock, 125 MHz.
  input  wire logic        presetn,       // Asynchronous reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB access phase.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [7:0]  paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error.
  output logic             spi_clk,       // Serial clock to device.
  output logic             chip_select_n, // Frame select, active low.
  output logic             sdio_out,      // Serial data toward device.
  output logic             sdio_oe,       // Host drives data line.
  input  wire logic        sdio_in        // Serial data from device.
);
  import sspi_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Constants of the serial timing.

  // Last divider count of each half period.
  localparam logic [3:0] HALF_LAST = 4'(`SSPI_HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////
  // All state of the host in one record.
  typedef struct packed {
    sspi_state_e   st;    // Engine phase.
    logic [3:0]    div;   // Half period counter.
    logic [5:0]    bits;  // Bit index in frame.
    logic [5:0]    total; // Bits in frame.
    logic [39:0]   tx;    // Outgoing shift word.
    logic [7:0]    rxb;   // Incoming byte.
    logic          rd;    // Frame is a read.
    logic          three; // Shared data line mode.
    logic [31:0]   ctrl;  // Control register.
    logic [31:0]   wdata; // Write data register.
    logic [31:0]   rdata; // Read data register.
    logic          done;  // Sticky frame done.
    sspi_pin_out_s pin;   // Serial pins.
  } sspi_host_s;

  sspi_host_s cur;  // Registered state.
  sspi_host_s next; // Next state.

  sspi_wr_s    sel;     // Register decode from the APB slave.
  logic [31:0] rd_word; // Read value of the selected register.
  logic        din;     // Synchronised device data.

  ////////////////////////////////////////////////////////////////
  // APB slave front end.
  sspi_apb u_apb
  (
    .pclk    (pclk),
    .presetn (presetn),
    .req     ({psel, penable, pwrite, paddr, pwdata}),
    .rd_word (rd_word),
    .sel     (sel),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  ////////////////////////////////////////////////////////////////
  // Input pin crossing: two flops before any use.
  sspi_sync u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (sdio_in),
    .sync_out (din)
  );

  ////////////////////////////////////////////////////////////////
  // Read multiplexer for the four host registers.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (sel.idx)
      `SSPI_OFF_CTRL:
        rd_word = cur.ctrl;
      `SSPI_OFF_WDATA:
        rd_word = cur.wdata;
      `SSPI_OFF_RDATA:
        rd_word = cur.rdata;
      `SSPI_OFF_STATUS:
      begin
        // Busy shows the engine itself, not a copy.
        rd_word[`SSPI_STAT_BUSY] = (cur.st != ST_IDLE);
        rd_word[`SSPI_STAT_DONE] = cur.done;
      end
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Next state: register writes first, then the engine, so that
  // a done event in the clearing cycle wins over the clear.
  always_comb
  begin
    logic       start;  // Go accepted this cycle.
    logic       rd_req; // Direction of the new frame.
    logic [5:0] dbits;  // Data bits of the new frame.
    logic [5:0] first;  // First data bit index.
    logic [2:0] bsel;   // Byte slot of a read byte.
    logic [7:0] rbyte;  // Completed read byte.
    start  = 1'b0;
    rd_req = 1'b0;
    dbits  = 6'd0;
    first  = 6'd0;
    bsel   = 3'd0;
    rbyte  = 8'h00;
    next   = cur;

    // Software writes to the host registers.
    if (sel.wr)
    begin
      case (sel.idx)
        `SSPI_OFF_CTRL:
        begin
          // Go is a strobe and never stored.
          next.ctrl = sel.data;
          next.ctrl[`SSPI_CTRL_GO] = 1'b0;
          start = sel.data[`SSPI_CTRL_GO] && (cur.st == ST_IDLE);
        end
        `SSPI_OFF_WDATA:
          next.wdata = sel.data;
        `SSPI_OFF_STATUS:
        begin
          // Done clears by writing one.
          if (sel.data[`SSPI_STAT_DONE])
            next.done = 1'b0;
        end
        default:
          next.ctrl = next.ctrl;
      endcase
    end

    // Engine.
    case (cur.st)
      ST_IDLE:
      begin
        // Idle port: select high, line released.
        next.pin.chip_select_n = 1'b1;
        next.pin.sclk          = 1'b0;
        next.pin.sdio_oe       = 1'b0;
        if (start)
        begin
          rd_req     = sel.data[`SSPI_CTRL_READ_BIT];
          // One to four bytes, from the count field plus one.
          dbits = {({1'b0, sel.data[`SSPI_CTRL_CNT_LSB +: 2]} + 3'd1), 3'b000};
          next.rd    = rd_req;
          next.three = sel.data[`SSPI_CTRL_WIRE3];
          // Write: command and data; read adds a turnaround byte.
          next.total = `SSPI_CMD_BITS + (rd_req ? `SSPI_BYTE_BITS : 6'd0) + dbits;
          // Flag, seven address bits, then data, first byte first.
          next.tx = {rd_req, sel.data[`SSPI_CTRL_ADDR_LSB +: 7],
                     rd_req ? 32'h0000_0000 :
                     {cur.wdata[7:0], cur.wdata[15:8], cur.wdata[23:16], cur.wdata[31:24]}};
          if (rd_req)
            next.rdata = `SSPI_RDATA_RESET;
          next.bits  = 6'd0;
          next.div   = 4'd0;
          // Select falls with the clock low: the frame opens here.
          next.pin.chip_select_n = 1'b0;
          next.pin.sdio_out      = rd_req;
          next.pin.sdio_oe       = 1'b1;
          next.st    = ST_LOW;
        end
      end

      ST_LOW:
      begin
        // Data has been steady for a half period; raise the clock.
        if (cur.div == HALF_LAST)
        begin
          next.div      = 4'd0;
          next.pin.sclk = 1'b1;
          next.st       = ST_HIGH;
        end
        else
          next.div = cur.div + 4'd1;
      end

      ST_HIGH:
      begin
        // Capture late in the high phase: the synchroniser delay
        // then still sees the bit driven at the previous fall.
        if (cur.div == HALF_LAST)
        begin
          next.div      = 4'd0;
          next.pin.sclk = 1'b0;
          next.bits     = cur.bits + 6'd1;
          next.rxb      = {cur.rxb[6:0], din};
          first = cur.rd ? (`SSPI_CMD_BITS + `SSPI_BYTE_BITS) : `SSPI_CMD_BITS;
          // Store each finished read byte in its own slot.
          if (cur.rd && (cur.bits >= first) && (cur.bits[2:0] == 3'd7))
          begin
            bsel  = cur.bits[5:3] - 3'd2;
            rbyte = {cur.rxb[6:0], din};
            next.rdata[{bsel[1:0], 3'b000} +: 8] = rbyte;
          end
          // Next bit goes out with the falling edge.
          next.tx           = {cur.tx[38:0], 1'b0};
          next.pin.sdio_out = cur.tx[38];
          // Shared line: in a read, release it once command is sent.
          if (cur.three && cur.rd && (cur.bits == `SSPI_CMD_BITS - 6'd1))
            next.pin.sdio_oe = 1'b0;
          if (cur.bits == cur.total - 6'd1)
            next.st = ST_TRAIL;
          else
            next.st = ST_LOW;
        end
        else
          next.div = cur.div + 4'd1;
      end

      ST_TRAIL:
      begin
        // Hold select low past the last fall, then release.
        if (cur.div == HALF_LAST)
        begin
          next.div               = 4'd0;
          next.pin.chip_select_n = 1'b1;
          next.pin.sdio_oe       = 1'b0;
          next.pin.sdio_out      = 1'b0;
          next.st                = ST_GAP;
        end
        else
          next.div = cur.div + 4'd1;
      end

      ST_GAP:
      begin
        // Least high time before another frame may open.
        if (cur.div == HALF_LAST)
        begin
          next.div  = 4'd0;
          next.done = 1'b1;
          next.st   = ST_IDLE;
        end
        else
          next.div = cur.div + 4'd1;
      end

      default:
      begin
        next.st                = ST_IDLE;
        next.pin.chip_select_n = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur                   <= '0;
      cur.st                <= ST_IDLE;
      cur.ctrl              <= `SSPI_CTRL_RESET;
      cur.wdata             <= `SSPI_WDATA_RESET;
      cur.rdata             <= `SSPI_RDATA_RESET;
      cur.pin.chip_select_n <= 1'b1;
    end
    else
      cur <= next;
  end

  ////////////////////////////////////////////////////////////////
  // Pins come straight from the state flops.
  assign spi_clk       = cur.pin.sclk;
  assign chip_select_n = cur.pin.chip_select_n;
  assign sdio_out      = cur.pin.sdio_out;
  assign sdio_oe       = cur.pin.sdio_oe;

endmodule // sspi_host

/* src/sspi_map.svh */
/*
  Constants of the serial sensor host: offsets, field positions,
  reset values and timing counts. Assumes a 125 MHz pclk.
*/
// How it works
// - Host starts every frame and makes all clocks
// - Write frames carry at least 16 clocks
// - Read frames carry at least 24 clocks
// - Falling chip select opens each frame
// - Host changes data low, device samples rising
// - Device drives falling, host captures after rising
// - Every field travels most significant bit first
// - Flag 0 writes: address then data byte
// - Flag 1 reads: address, a turnaround byte, then register contents
// - Chip select stays high while port idles
`ifndef SSPI_MAP_SVH
`define SSPI_MAP_SVH

////////////////////////////////////////////////////////////////
// Host register offsets (word index from paddr[3:2] on APB).
`define SSPI_OFF_CTRL   2'h0
`define SSPI_OFF_WDATA  2'h1
`define SSPI_OFF_RDATA  2'h2
`define SSPI_OFF_STATUS 2'h3

// Control word fields.
`define SSPI_CTRL_ADDR_LSB 0
`define SSPI_CTRL_READ_BIT 7
`define SSPI_CTRL_CNT_LSB  8
`define SSPI_CTRL_WIRE3    10
`define SSPI_CTRL_GO       31
`define SSPI_CTRL_RESET    32'h0000_0000
`define SSPI_WDATA_RESET   32'h0000_0000
`define SSPI_RDATA_RESET   32'h0000_0000

// Status word fields.
`define SSPI_STAT_BUSY 0
`define SSPI_STAT_DONE 1

////////////////////////////////////////////////////////////////
// Timing: half serial period from the least clock cycle.
`define SSPI_CLK_NS   8
`define SSPI_HALF_NS  50
`define SSPI_HALF_CYC ((`SSPI_HALF_NS + `SSPI_CLK_NS - 1) / `SSPI_CLK_NS)
`define SSPI_CMD_BITS  6'd8
`define SSPI_BYTE_BITS 6'd8

////////////////////////////////////////////////////////////////
// Device register map, 7-bit addresses.
`define SSPI_DEV_DEVICE_STATUS     7'h05
`define SSPI_DEV_INTERRUPT_ENABLE  7'h06
`define SSPI_DEV_OPERATING_MODE    7'h07
`define SSPI_DEV_SAMPLE_RATE       7'h08
`define SSPI_DEV_MOTION_CONTROL    7'h09
`define SSPI_DEV_QUEUE_STATUS      7'h0a
`define SSPI_DEV_QUEUE_RD_PTR      7'h0b
`define SSPI_DEV_QUEUE_WR_PTR      7'h0c
`define SSPI_DEV_X_ACCEL_LOW       7'h0d
`define SSPI_DEV_X_ACCEL_HIGH      7'h0e
`define SSPI_DEV_Y_ACCEL_LOW       7'h0f
`define SSPI_DEV_Y_ACCEL_HIGH      7'h10
`define SSPI_DEV_Z_ACCEL_LOW       7'h11
`define SSPI_DEV_Z_ACCEL_HIGH      7'h12
`define SSPI_DEV_EVENT_FLAGS       7'h13
`define SSPI_DEV_INTERRUPT_STATUS  7'h14
`define SSPI_DEV_PART_ID           7'h18
`define SSPI_DEV_RANGE_AND_FILTER  7'h20
`define SSPI_DEV_X_OFFSET_LOW      7'h21
`define SSPI_DEV_RESET_VALUE       8'h00

`endif

/* src/sspi_pkg.sv */
/*
  Types shared by the serial sensor host modules.
  Assumes the constants header is compiled alongside.
*/
package sspi_pkg;

  // Serial engine phases.
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_TRAIL,
    ST_GAP
  } sspi_state_e;

  // One APB request as seen by the slave.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sspi_apb_req_s;

  // Decoded register select and write strobe.
  typedef struct packed {
    logic        hit;
    logic        wr;
    logic [1:0]  idx;
    logic [31:0] data;
  } sspi_wr_s;

  // Serial pins driven by the host.
  typedef struct packed {
    logic chip_select_n;
    logic sclk;
    logic sdio_out;
    logic sdio_oe;
  } sspi_pin_out_s;

endpackage : sspi_pkg

/* src/sspi_sync.sv */
/*
  Two-stage synchroniser for the serial data input pin.
  Assumes the input is asynchronous to pclk.
*/
module sspi_sync
(
  input  wire logic pclk,    // System clock.
  input  wire logic presetn, // Asynchronous reset, active low.
  input  wire logic pin_in,  // Raw pin level.
  output logic      sync_out // Level after two flops.
);
  import sspi_pkg::*;

  // Both stages; only the second is read outside.
  typedef struct packed {
    logic s1;
    logic s2;
  } sspi_sync_s;

  sspi_sync_s cur;  // Registered state.
  sspi_sync_s next; // Next state.

  // The first stage feeds only the second.
  always_comb
  begin
    next    = cur;
    next.s1 = pin_in;
    next.s2 = cur.s1;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur <= '0;
    else
      cur <= next;
  end

  assign sync_out = cur.s2;
endmodule // sspi_sync

/* src/sspi_apb.sv */
/*
  APB slave front end: decodes the four host registers and
  answers every transfer with one access cycle.
  Assumes the read word for the addressed register is given.
*/
`include "sspi_map.svh"
module sspi_apb
(
  input  wire logic                  pclk,    // System clock.
  input  wire logic                  presetn, // Reset, active low.
  input  sspi_pkg::sspi_apb_req_s    req,     // APB request.
  input  wire logic [31:0]           rd_word, // Selected read value.
  output sspi_pkg::sspi_wr_s         sel,     // Decode and write strobe.
  output logic [31:0]                prdata,  // Read data.
  output logic                       pready,  // Transfer done.
  output logic                       pslverr  // Unmapped address.
);
  import sspi_pkg::*;

  // Answer flops.
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sspi_apb_st_s;

  sspi_apb_st_s cur;  // Registered answer.
  sspi_apb_st_s next; // Next answer.

  ////////////////////////////////////////////////////////////////
  // Decode: four aligned words at the bottom of the window.
  always_comb
  begin
    sel.hit  = (req.paddr[7:4] == 4'h0) && (req.paddr[1:0] == 2'h0);
    sel.idx  = req.paddr[3:2];
    sel.data = req.pwdata;
    // A write lands only at the edge that completes it.
    sel.wr   = req.psel & req.penable & cur.pready & req.pwrite & sel.hit;
  end

  // The answer is prepared in the setup cycle, so pready is a flop.
  always_comb
  begin
    next        = cur;
    next.pready = req.psel & ~req.penable & ~cur.pready;
    if (req.psel && !req.penable)
    begin
      next.prdata  = (sel.hit && !req.pwrite) ? rd_word : 32'h0000_0000;
      next.pslverr = ~sel.hit;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur <= '0;
    else
      cur <= next;
  end

  assign prdata  = cur.prdata;
  assign pready  = cur.pready;
  assign pslverr = cur.pslverr;
endmodule // sspi_apb

/* dv/sspi_host_monitor.sv */
/*
  Checker for the serial sensor host: APB answer timing and serial frame shape.
  Assumes it is bound to sspi_host and sees only that module's ports.
*/
module sspi_host_monitor
(
  input wire logic        pclk,          // System clock.
  input wire logic        presetn,       // Reset, active low.
  input wire logic        psel,          // APB select.
  input wire logic        penable,       // APB access phase.
  input wire logic        pwrite,        // APB direction.
  input wire logic [7:0]  paddr,         // APB address.
  input wire logic [31:0] pwdata,        // APB write data.
  input wire logic [31:0] prdata,        // APB read data.
  input wire logic        pready,        // APB ready.
  input wire logic        pslverr,       // APB error.
  input wire logic        spi_clk,       // Serial clock.
  input wire logic        chip_select_n, // Frame select, active low.
  input wire logic        sdio_out,      // Host data out.
  input wire logic        sdio_oe,       // Host drive enable.
  input wire logic        sdio_in        // Device data.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  // Frame bookkeeping: rising serial edges and the direction flag.
  logic [5:0] n_rise;   // Rising serial edges in the open frame.
  logic       rd_flag;  // First bit of the open frame.
  logic       clk_q;    // Serial clock one cycle ago.
  logic       bad_addr; // Address outside the four host words.
  assign bad_addr = (paddr[7:4] != 4'h0) || (paddr[1:0] != 2'h0);

  // Counter clears while deselected so a short frame cannot borrow old counts.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      n_rise  <= 6'h00;
      rd_flag <= 1'b0;
      clk_q   <= 1'b0;
    end
    else
    begin
      clk_q <= spi_clk;
      if (chip_select_n)
        n_rise <= 6'h00;
      else if (spi_clk && !clk_q)
      begin
        n_rise <= n_rise + 6'h01;
        if (n_rise == 6'h00)
          rd_flag <= sdio_out;
      end
    end
  end

  ////////////////////////////////////////
  property p_apb_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("pready not one cycle after setup");
  property p_apb_error;
    pready |-> (pslverr == bad_addr) && (!pslverr || prdata == 32'h0);
  endproperty
  a_apb_error: assert property (p_apb_error) else $error("pslverr or prdata wrong for address");
  property p_frame_cause;
    $fell(chip_select_n) |-> $past(psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[31]);
  endproperty
  a_frame_cause: assert property (p_frame_cause) else $error("frame opened without a start order");
  property p_frame_open;
    $fell(chip_select_n) |-> (sdio_oe && !spi_clk) [*7] ##1 spi_clk;
  endproperty
  a_frame_open: assert property (p_frame_open) else $error("first serial edge misplaced");
  property p_data_steady;
    spi_clk |-> $stable(sdio_out) && $stable(sdio_oe);
  endproperty
  a_data_steady: assert property (p_data_steady) else $error("host data moved while clock high");
  property p_high_phase;
    $rose(spi_clk) |-> spi_clk [*7] ##1 !spi_clk;
  endproperty
  a_high_phase: assert property (p_high_phase) else $error("serial high phase not 7 cycles");
  property p_low_phase;
    $fell(spi_clk) |-> !spi_clk [*7] ##1 (spi_clk || chip_select_n);
  endproperty
  a_low_phase: assert property (p_low_phase) else $error("serial low phase not 7 cycles");
  property p_write_len;
    $rose(chip_select_n) |-> n_rise >= 6'd16 && n_rise[2:0] == 3'h0;
  endproperty
  a_write_len: assert property (p_write_len) else $error("frame length not whole bytes");
  property p_read_len;
    $rose(chip_select_n) && rd_flag |-> n_rise >= 6'd24;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read frame too short");
  property p_turn;
    $fell(sdio_oe) && !chip_select_n |-> rd_flag && n_rise == 6'd8;
  endproperty
  a_turn: assert property (p_turn) else $error("shared line released at wrong bit");
endmodule // sspi_host_monitor

/* dv/sspi_dev_model.sv */
/*
  Behavioural model of the sensor's serial register port.
  Assumes the host makes the serial clock and frames each transfer.
*/
module sspi_dev_model
#(
  parameter logic [7:0] PART_ID    = 8'h5a, // Arbitrary identification value.
  parameter logic [1:0] WAKE_STATE = 2'h1   // Mode state value taken as awake.
)
(
  input  wire logic spi_clk,       // Serial clock from the host.
  input  wire logic chip_select_n, // Frame select, active low.
  input  wire logic mosi,          // Data from the host.
  output logic      miso,          // Data toward the host.
  output logic      miso_oe        // Model drives its data.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:127]; // Register file.
  logic [7:0] shreg;       // Incoming bits.
  logic [6:0] base;        // Start address of the frame.
  logic       rd;          // Frame is a read.
  int         cnt;         // Rising edges in this frame.

  // Power-on values: all zero except the identification byte.
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    mem[7'h18] = PART_ID;
    miso       = 1'b0;
    miso_oe    = 1'b0;
    cnt        = 0;
    rd         = 1'b0;
  end

  // Read-only and reserved places drop writes; awake only the mode byte takes them.
  function automatic logic can_write(input logic [6:0] a);
    if (mem[7][1:0] == WAKE_STATE && a != 7'h07)
      return 1'b0;
    return a inside {[7'h06:7'h09], 7'h20, 7'h21};
  endfunction

  ////////////////////////////////////////
  always @(negedge chip_select_n)
    cnt = 0;

  // Input bits are taken on rising edges, first bit the direction flag.
  always @(posedge spi_clk)
  begin
    if (!chip_select_n)
    begin
      shreg = {shreg[6:0], mosi};
      cnt   = cnt + 1;
      if (cnt == 8)
      begin
        rd   = shreg[7];
        base = shreg[6:0];
      end
      else if (!rd && cnt % 8 == 0 && can_write(base + 7'((cnt - 16) / 8)))
        mem[base + 7'((cnt - 16) / 8)] = shreg;
    end
  end

  // Output bits change on falling edges; an idle line toggles so nothing stale looks valid.
  // Status bytes never change here, so they are trivially frozen during frames.
  always @(negedge spi_clk or posedge chip_select_n)
  begin
    if (!chip_select_n && rd && cnt >= 16)
    begin
      miso_oe = 1'b1;
      miso    = mem[base + 7'((cnt - 16) / 8)][7 - (cnt - 16) % 8];
    end
    else
    begin
      miso_oe = 1'b0;
      miso    = ~miso;
    end
  end
endmodule // sspi_dev_model

/* dv/sensor_spi_register_port_bench.sv */
/*
  Testbench of the serial sensor host: APB orders, frames checked through a device model.
  Assumes the host map header offsets and the model in the same compile.
*/
module sensor_spi_register_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PART_ID = 8'h5a; // Arbitrary identification value.
  logic        pclk = 1'b0; // System clock.
  logic        presetn;     // Reset, active low.
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, e;
  logic        spi_clk, chip_select_n, sdio_out, sdio_oe, sdio_in;
  logic        wire3, miso, miso_oe, dev_in, line_3w;
  int          num_errors = 0;
  int          n_checks = 0;

  always #4 pclk = ~pclk;
  // Shared wire: the host wins while enabled, else the device's (toggling when idle) level.
  assign line_3w = sdio_oe ? sdio_out : miso;
  assign sdio_in = wire3 ? line_3w : miso;
  assign dev_in  = wire3 ? line_3w : sdio_out;

  // Shared wire: the two ends must never drive it in the same cycle.
  always @(posedge pclk)
    if (wire3 && sdio_oe === 1'b1 && miso_oe === 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t shared line driven by both ends", $time);
    end

  sspi_host dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                 .pslverr, .spi_clk, .chip_select_n, .sdio_out, .sdio_oe, .sdio_in);
  sspi_dev_model #(.PART_ID(PART_ID)) dev (.spi_clk, .chip_select_n, .mosi(dev_in), .miso, .miso_oe);

  ////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; entered just after an edge, leaves one idle cycle behind it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    int waits;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    waits = 0;
    do
    begin
      @(posedge pclk);
      waits++;
    end
    while (pready !== 1'b1 && waits < 50);
    chk({31'h0, pready}, 32'h1);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Runs one frame: busy seen at once, done cleared afterwards, read word returned.
  task automatic frame(input logic rd, input logic [6:0] a, input logic [1:0] nm1, input logic w3,
                       input logic [31:0] wd, output logic [31:0] rw);
    logic [31:0] s;
    logic        x;
    int          n;
    wire3 <= w3;
    apb(1'b1, 8'h04, wd, s, x);
    apb(1'b1, 8'h00, {1'b1, 20'h0, w3, nm1, rd, a}, s, x);
    apb(1'b0, 8'h0c, 32'h0, s, x);
    chk(s, 32'h1);
    n = 0;
    do
    begin
      apb(1'b0, 8'h0c, 32'h0, s, x);
      n++;
    end
    while (s[1] !== 1'b1 && n < 500);
    chk(s, 32'h2);
    apb(1'b1, 8'h0c, 32'h2, s, x);
    apb(1'b0, 8'h0c, 32'h0, s, x);
    chk(s, 32'h0);
    apb(1'b0, 8'h08, 32'h0, rw, x);
  endtask

  ////////////////////////////////////////
  initial
  begin
    #400000;
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, wire3} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Host words come out of reset cleared.
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0, q, e);
      chk(q, 32'h0);
    end
    // Unmapped and misaligned places answer with an error and change nothing.
    apb(1'b1, 8'h10, 32'hffff_ffff, q, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h06, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk(q, 32'h0);
    // Single write then single read, four wires.
    frame(1'b0, 7'h06, 2'h0, 1'b0, 32'h0000_00a5, q);
    frame(1'b1, 7'h06, 2'h0, 1'b0, 32'h0, q);
    chk(q, 32'h0000_00a5);
    // Four-byte burst write, read back as a burst over the shared wire.
    frame(1'b0, 7'h06, 2'h3, 1'b0, 32'h2c05_3011, q);
    frame(1'b1, 7'h06, 2'h3, 1'b1, 32'h0, q);
    chk(q, 32'h2c05_3011);
    // Identification byte and a read-only place that must drop a write.
    frame(1'b1, 7'h18, 2'h0, 1'b1, 32'h0, q);
    chk(q, {24'h0, PART_ID});
    frame(1'b0, 7'h05, 2'h0, 1'b0, 32'h0000_00ff, q);
    // Three-byte burst: the dropped byte, then two bytes of the earlier burst.
    frame(1'b1, 7'h05, 2'h2, 1'b0, 32'h0, q);
    chk(q, 32'h0030_1100);
    // Awake device takes only the mode byte.
    frame(1'b0, 7'h07, 2'h0, 1'b0, 32'h0000_0001, q);
    frame(1'b0, 7'h08, 2'h0, 1'b0, 32'h0000_0007, q);
    frame(1'b1, 7'h07, 2'h1, 1'b1, 32'h0, q);
    chk(q, 32'h0000_0501);
    complete_run();
  end
endmodule // sensor_spi_register_port_bench

bind sspi_host sspi_host_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .spi_clk, .chip_select_n, .sdio_out, .sdio_oe, .sdio_in);
